/* common/pgc_pkg.sv */
// Notes on behaviour
// - select bit 31 hands radio block power to baseband when one, else to direct and sleep bits 21..12.
// - sleep bit 23 cuts slow crystal supply during sleep when set.
// - sleep bit 10 cuts RC oscillator supply during sleep when set.
// - sleep bits 7..1 cut matching memory bank during sleep.
// - sleep bit 9, reset one, drives bonding option enable.
// - direct bit 31, reset one, sets RC oscillator supply level high.
// - direct bit 30 switches fast oscillator off when one.
// - direct bits 29..23 cut bandgap through slow crystal when one.
// - direct bit 22, reset one, switches reference PLL off.
// - direct bits 21..12 gate radio blocks only when select bit is zero.
// - direct bits 11 and 10 switch off SAR converter and RC oscillator.
// - direct bits 7..1 cut memory banks at once, regardless of sleep.
`default_nettype none
package pgc_pkg;
    localparam logic [11:0] PGC_ADDR_ID     = 12'h000;
    localparam logic [11:0] PGC_ADDR_SLEEP  = 12'h004;
    localparam logic [11:0] PGC_ADDR_DIRECT = 12'h008;
    localparam logic [11:0] PGC_ADDR_STATE  = 12'h00C;
    // identification value is arbitrary
    localparam logic [15:0] PGC_ID_CODE     = 16'h5A3C;
    localparam logic [31:0] PGC_SLEEP_RST   = 32'hFF7F_FA00;
    localparam logic [31:0] PGC_SLEEP_MASK  = 32'hFFFF_FEFF;
    localparam logic [31:0] PGC_DIRECT_RST  = 32'h807F_FC00;
    localparam logic [31:0] PGC_DIRECT_MASK = 32'hFFFF_FCFF;
    localparam int PGC_B_SEL      = 31;
    localparam int PGC_B_OSC      = 30;
    localparam int PGC_B_BG       = 29;
    localparam int PGC_B_XT32     = 23;
    localparam int PGC_B_PLL      = 22;
    localparam int PGC_B_RADIO_HI = 21;
    localparam int PGC_B_RADIO_LO = 12;
    localparam int PGC_B_SAR      = 11;
    localparam int PGC_B_RCO      = 10;
    localparam int PGC_B_BOND     = 9;
    localparam int PGC_B_MEM_HI   = 7;
    localparam int PGC_B_MEM_LO   = 1;
    localparam int PGC_B_VREGLP   = 0;
    typedef struct packed {
        logic       rc_osc_supply_level;
        logic       fast_osc_off;
        logic [6:0] analog_off;
        logic       reference_pll_off;
        logic [9:0] radio_off;
        logic       sar_converter_off;
        logic       rc_osc_off;
        logic [6:0] membank_off;
        logic       bond_enable;
        logic       digital_regulator_lowpower_n;
    } pgc_power_t;
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } pgc_apb_req_t;
endpackage
`default_nettype wire

/* logic/pgc_word_reg.sv */
`default_nettype none
module pgc_word_reg #(
    parameter logic [31:0] RST  = 32'h0000_0000,
    parameter logic [31:0] MASK = 32'hFFFF_FFFF
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // write side
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    // stored value
    output logic [31:0]      q
);
    logic [31:0] q_next;
    // a reset value outside the mask could never be written back
    if ((RST & ~MASK) != 32'h0000_0000) begin
        $error("reset value sets masked bits");
    end
    always_comb begin
        q_next = q;
        if (wr) begin
            q_next = wdata & MASK;
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= RST;
        end else begin
            q <= q_next;
        end
    end
endmodule
`default_nettype wire

/* logic/pgc_regs.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
module pgc_regs (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                reset,
    // apb slave
    input  wire pgc_pkg::pgc_apb_req_t apb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // baseband radio control
    input  wire logic [9:0]          bb_radio_off,
    // power outputs
    output pgc_pkg::pgc_power_t      pwr
);
    import pgc_pkg::*;

    logic [31:0] sleep_reg;
    logic [31:0] direct_reg;
    logic        sleep_state_flag_reg;
    logic        sleep_state_flag_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        wr_en;
    logic        rd_en;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a[11:2] == b[11:2];
    endfunction

    // single-cycle access: ready in every access phase
    assign pready  = 1'b1;
    assign wr_en   = apb.psel & apb.penable & apb.pwrite;
    assign rd_en   = apb.psel & ~apb.penable & ~apb.pwrite;
    assign pslverr = apb.psel & apb.penable & ~(hit(apb.paddr, PGC_ADDR_ID)
                   | hit(apb.paddr, PGC_ADDR_SLEEP)
                   | hit(apb.paddr, PGC_ADDR_DIRECT)
                   | hit(apb.paddr, PGC_ADDR_STATE));
    assign prdata  = prdata_reg;

    pgc_word_reg #(.RST(PGC_SLEEP_RST), .MASK(PGC_SLEEP_MASK)) u_sleep (
        .mclk  (mclk),
        .reset (reset),
        .wr    (wr_en & hit(apb.paddr, PGC_ADDR_SLEEP)),
        .wdata (apb.pwdata),
        .q     (sleep_reg)
    );
    pgc_word_reg #(.RST(PGC_DIRECT_RST), .MASK(PGC_DIRECT_MASK)) u_direct (
        .mclk  (mclk),
        .reset (reset),
        .wr    (wr_en & hit(apb.paddr, PGC_ADDR_DIRECT)),
        .wdata (apb.pwdata),
        .q     (direct_reg)
    );

    always_comb begin
        sleep_state_flag_next = sleep_state_flag_reg;
        if (wr_en && hit(apb.paddr, PGC_ADDR_STATE)) begin
            sleep_state_flag_next = apb.pwdata[0];
        end
        // read data latched in setup so it stands through the access
        prdata_next = prdata_reg;
        if (rd_en) begin
            prdata_next = 32'h0000_0000;
            if (hit(apb.paddr, PGC_ADDR_ID)) begin
                prdata_next = {16'h0000, PGC_ID_CODE};
            end else if (hit(apb.paddr, PGC_ADDR_SLEEP)) begin
                prdata_next = sleep_reg;
            end else if (hit(apb.paddr, PGC_ADDR_DIRECT)) begin
                prdata_next = direct_reg;
            end else if (hit(apb.paddr, PGC_ADDR_STATE)) begin
                prdata_next = {31'h0000_0000, sleep_state_flag_reg};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sleep_state_flag_reg <= 1'b0;
            prdata_reg           <= 32'h0000_0000;
        end else begin
            sleep_state_flag_reg <= sleep_state_flag_next;
            prdata_reg           <= prdata_next;
        end
    end

    logic slp;
    assign slp = sleep_state_flag_reg;

    assign pwr.rc_osc_supply_level = direct_reg[31];
    assign pwr.fast_osc_off = direct_reg[PGC_B_OSC]
                            | (slp & sleep_reg[PGC_B_OSC]);
    assign pwr.analog_off = direct_reg[PGC_B_BG:PGC_B_XT32]
                          | ({7{slp}} & sleep_reg[PGC_B_BG:PGC_B_XT32]);
    assign pwr.reference_pll_off = direct_reg[PGC_B_PLL]
                                 | (slp & sleep_reg[PGC_B_PLL]);
    assign pwr.radio_off = sleep_reg[PGC_B_SEL] ? bb_radio_off
                         : (direct_reg[PGC_B_RADIO_HI:PGC_B_RADIO_LO]
                         | ({10{slp}}
                         & sleep_reg[PGC_B_RADIO_HI:PGC_B_RADIO_LO]));
    assign pwr.sar_converter_off = direct_reg[PGC_B_SAR]
                                 | (slp & sleep_reg[PGC_B_SAR]);
    assign pwr.rc_osc_off = direct_reg[PGC_B_RCO]
                          | (slp & sleep_reg[PGC_B_RCO]);
    assign pwr.membank_off = direct_reg[PGC_B_MEM_HI:PGC_B_MEM_LO]
                           | ({7{slp}}
                           & sleep_reg[PGC_B_MEM_HI:PGC_B_MEM_LO]);
    assign pwr.bond_enable = sleep_reg[PGC_B_BOND];
    assign pwr.digital_regulator_lowpower_n = sleep_reg[PGC_B_VREGLP];

    property p_mem_direct;
        @(posedge mclk) disable iff (reset)
        direct_reg[1] |-> pwr.membank_off[0];
    endproperty
    a_mem_direct: assert property (p_mem_direct)
        else $error("bank not cut by direct bit");
    property p_mem_sleep;
        @(posedge mclk) disable iff (reset)
        (!slp && !direct_reg[7]) |-> !pwr.membank_off[6];
    endproperty
    a_mem_sleep: assert property (p_mem_sleep)
        else $error("bank cut while awake");
    property p_radio_bb;
        @(posedge mclk) disable iff (reset)
        sleep_reg[31] |-> pwr.radio_off == bb_radio_off;
    endproperty
    a_radio_bb: assert property (p_radio_bb)
        else $error("radio not from baseband");
    property p_radio_dir;
        @(posedge mclk) disable iff (reset)
        (!sleep_reg[31] && direct_reg[21]) |-> pwr.radio_off[9];
    endproperty
    a_radio_dir: assert property (p_radio_dir)
        else $error("radio disable ignored");
    property p_id;
        @(posedge mclk) disable iff (reset)
        (rd_en && apb.paddr == PGC_ADDR_ID) |=> prdata == {16'h0000, PGC_ID_CODE};
    endproperty
    a_id: assert property (p_id)
        else $error("bad id read");
    property p_rsvd;
        @(posedge mclk) disable iff (reset)
        !sleep_reg[8] && direct_reg[9:8] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");
    property p_xt32;
        @(posedge mclk) disable iff (reset)
        (slp && sleep_reg[23]) |-> pwr.analog_off[0];
    endproperty
    a_xt32: assert property (p_xt32)
        else $error("slow crystal on in sleep");
    property p_rco;
        @(posedge mclk) disable iff (reset)
        pwr.rc_osc_off == (direct_reg[10] || (slp && sleep_reg[10]));
    endproperty
    a_rco: assert property (p_rco)
        else $error("rc oscillator gate wrong");
    property p_pll;
        @(posedge mclk) disable iff (reset)
        $rose(direct_reg[22]) |-> pwr.reference_pll_off;
    endproperty
    a_pll: assert property (p_pll)
        else $error("pll not off");
    property p_bond;
        @(posedge mclk) disable iff (reset)
        $fell(sleep_reg[9]) |-> !pwr.bond_enable;
    endproperty
    a_bond: assert property (p_bond)
        else $error("bond enable stuck");
    property p_osc;
        @(posedge mclk) disable iff (reset)
        direct_reg[30] |-> pwr.fast_osc_off && pwr.rc_osc_supply_level
                           == direct_reg[31];
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator gate wrong");
    property p_level;
        @(posedge mclk) disable iff (reset)
        pwr.rc_osc_supply_level == direct_reg[31];
    endproperty
    a_level: assert property (p_level)
        else $error("supply level wrong");
    property p_osc_sleep;
        @(posedge mclk) disable iff (reset)
        (slp && sleep_reg[30]) |-> pwr.fast_osc_off;
    endproperty
    a_osc_sleep: assert property (p_osc_sleep)
        else $error("oscillator on in sleep");
    property p_analog_dir;
        @(posedge mclk) disable iff (reset)
        (direct_reg[29:23] & ~pwr.analog_off) == 7'h00;
    endproperty
    a_analog_dir: assert property (p_analog_dir)
        else $error("analog block not cut");
    property p_analog_awake;
        @(posedge mclk) disable iff (reset)
        !slp |-> pwr.analog_off == direct_reg[29:23];
    endproperty
    a_analog_awake: assert property (p_analog_awake)
        else $error("analog cut while awake");
    property p_xt32_awake;
        @(posedge mclk) disable iff (reset)
        (!slp && !direct_reg[23]) |-> !pwr.analog_off[0];
    endproperty
    a_xt32_awake: assert property (p_xt32_awake)
        else $error("slow crystal off while awake");
    property p_pll_on;
        @(posedge mclk) disable iff (reset)
        (!slp && !direct_reg[22]) |-> !pwr.reference_pll_off;
    endproperty
    a_pll_on: assert property (p_pll_on)
        else $error("pll off while enabled");
    property p_radio_sleep;
        @(posedge mclk) disable iff (reset)
        (!sleep_reg[31] && slp) |-> pwr.radio_off
            == (direct_reg[21:12] | sleep_reg[21:12]);
    endproperty
    a_radio_sleep: assert property (p_radio_sleep)
        else $error("radio gate wrong in sleep");
    property p_radio_awake;
        @(posedge mclk) disable iff (reset)
        (!sleep_reg[31] && !slp) |-> pwr.radio_off == direct_reg[21:12];
    endproperty
    a_radio_awake: assert property (p_radio_awake)
        else $error("radio gate wrong awake");
    property p_sar;
        @(posedge mclk) disable iff (reset)
        pwr.sar_converter_off == (direct_reg[11] || (slp && sleep_reg[11]));
    endproperty
    a_sar: assert property (p_sar)
        else $error("sar converter gate wrong");
    property p_rco_dir;
        @(posedge mclk) disable iff (reset)
        direct_reg[10] |-> pwr.rc_osc_off;
    endproperty
    a_rco_dir: assert property (p_rco_dir)
        else $error("rc oscillator not off");
    property p_mem_awake;
        @(posedge mclk) disable iff (reset)
        !slp |-> pwr.membank_off == direct_reg[7:1];
    endproperty
    a_mem_awake: assert property (p_mem_awake)
        else $error("bank gate wrong awake");
    property p_mem_asleep;
        @(posedge mclk) disable iff (reset)
        slp |-> pwr.membank_off == (direct_reg[7:1] | sleep_reg[7:1]);
    endproperty
    a_mem_asleep: assert property (p_mem_asleep)
        else $error("bank gate wrong in sleep");
    property p_bond_lvl;
        @(posedge mclk) disable iff (reset)
        pwr.bond_enable == sleep_reg[9];
    endproperty
    a_bond_lvl: assert property (p_bond_lvl)
        else $error("bond enable level wrong");
    property p_rd_sleep_rsvd;
        @(posedge mclk) disable iff (reset)
        (rd_en && hit(apb.paddr, PGC_ADDR_SLEEP)) |=> !prdata[8];
    endproperty
    a_rd_sleep_rsvd: assert property (p_rd_sleep_rsvd)
        else $error("reserved sleep bit read one");
    property p_rd_dir_rsvd;
        @(posedge mclk) disable iff (reset)
        (rd_en && hit(apb.paddr, PGC_ADDR_DIRECT)) |=> prdata[9:8] == 2'b00;
    endproperty
    a_rd_dir_rsvd: assert property (p_rd_dir_rsvd)
        else $error("reserved direct bit read one");
    property p_id_hi;
        @(posedge mclk) disable iff (reset)
        (rd_en && hit(apb.paddr, PGC_ADDR_ID)) |=> prdata[31:16] == 16'h0000;
    endproperty
    a_id_hi: assert property (p_id_hi)
        else $error("id upper half not zero");
    property p_ready;
        @(posedge mclk) disable iff (reset)
        (apb.psel && apb.penable) |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access phase not ready");
    property p_prdata_hold;
        @(posedge mclk) disable iff (reset)
        !rd_en |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold)
        else $error("read data moved");
    property p_flag_hold;
        @(posedge mclk) disable iff (reset)
        !(wr_en && hit(apb.paddr, PGC_ADDR_STATE)) |=> $stable(slp);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("sleep flag moved");
    property p_dir_hold;
        @(posedge mclk) disable iff (reset)
        !(wr_en && hit(apb.paddr, PGC_ADDR_DIRECT)) |=> $stable(direct_reg);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direct register moved");
    c_radio_sleep: cover property (@(posedge mclk) slp && !sleep_reg[31]);
    c_id_rd: cover property (@(posedge mclk) rd_en && hit(apb.paddr, PGC_ADDR_ID));
    c_sleep: cover property (@(posedge mclk) $rose(slp));
    c_bb: cover property (@(posedge mclk) $fell(sleep_reg[31]));
    c_err: cover property (@(posedge mclk) pslverr);
endmodule
`default_nettype wire

/* sim/pgc_bb_model.sv */
`default_nettype none
module pgc_bb_model (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  reset,
    // radio power requests
    output logic [9:0] bb_radio_off
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] req_reg;
    logic [9:0] req_next;
    // pattern moves every cycle so a stale copy never matches by luck
    always_comb begin
        req_next = {req_reg[8:0], req_reg[9] ^ req_reg[6]};
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_reg <= 10'h2B5;
        end else begin
            req_reg <= req_next;
        end
    end
    assign bb_radio_off = req_reg;
endmodule
`default_nettype wire

/* sim/pgc_regs_tb_top.sv */
`default_nettype none
module pgc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pgc_pkg::*;
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    pgc_apb_req_t apb = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [9:0]   bb_radio_off;
    pgc_power_t   pwr;
    int           n_errors = 0;
    int           cmp_count = 0;
    always #10 mclk = ~mclk;
    pgc_regs pgc_regs_inst (.mclk(mclk), .reset(reset), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bb_radio_off(bb_radio_off), .pwr(pwr));
    pgc_bb_model pgc_bb_model_inst (.mclk(mclk), .reset(reset),
        .bb_radio_off(bb_radio_off));
    function automatic pgc_power_t exp_pwr(input logic [31:0] s, d,
        input logic f, input logic [9:0] bb);
        pgc_power_t e;
        logic [31:0] q;
        q = d | (s & {32{f}});
        e.rc_osc_supply_level = d[31];
        e.fast_osc_off = q[30];
        e.analog_off = q[29:23];
        e.reference_pll_off = q[22];
        e.radio_off = s[31] ? bb : q[21:12];
        e.sar_converter_off = q[11];
        e.rc_osc_off = q[10];
        e.membank_off = q[7:1];
        e.bond_enable = s[9];
        e.digital_regulator_lowpower_n = s[0];
        return e;
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h",
                $time, msg, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        @(posedge mclk);
        apb <= '{a, 1'b1, 1'b0, w, d};
        @(posedge mclk);
        apb.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        if (i == 16) begin
            n_errors++;
            $display("wrong value at %0t: no ready", $time);
            finish_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
        check(r, x, "read data");
        check({31'h0, e}, {31'h0, xe}, "slave error");
    endtask
    task automatic chk_pwr(input logic [31:0] s, d, input logic f);
        @(negedge mclk);
        check(32'(pwr), 32'(exp_pwr(s, d, f, bb_radio_off)), "power");
    endtask
    task automatic t_reset();
        rd(PGC_ADDR_ID, {16'h0000, PGC_ID_CODE}, 1'b0);
        rd(PGC_ADDR_SLEEP, 32'hFF7F_FA00, 1'b0);
        rd(PGC_ADDR_DIRECT, 32'h807F_FC00, 1'b0);
        rd(PGC_ADDR_STATE, 32'h0000_0000, 1'b0);
        chk_pwr(32'hFF7F_FA00, 32'h807F_FC00, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_refuse();
        wr(PGC_ADDR_ID, 32'hFFFF_FFFF);
        rd(PGC_ADDR_ID, {16'h0000, PGC_ID_CODE}, 1'b0);
        wr(12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h0000_0000, 1'b1);
        rd(PGC_ADDR_DIRECT, 32'h807F_FC00, 1'b0);
        $display("test refuse done");
    endtask
    task automatic t_mask();
        wr(PGC_ADDR_SLEEP, 32'hFFFF_FFFF);
        wr(PGC_ADDR_DIRECT, 32'hFFFF_FFFF);
        rd(PGC_ADDR_SLEEP, 32'hFFFF_FEFF, 1'b0);
        rd(PGC_ADDR_DIRECT, 32'hFFFF_FCFF, 1'b0);
        chk_pwr(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0);
        $display("test mask done");
    endtask
    task automatic t_direct();
        int b;
        // reserved ones kept, buck unused so its sleep bit is zero
        wr(PGC_ADDR_SLEEP, 32'h7F7F_F800);
        for (b = 1; b < 32; b++) begin
            if (b == 8 || b == 9) continue;
            wr(PGC_ADDR_DIRECT, 32'h1 << b);
            chk_pwr(32'h7F7F_F800, 32'h1 << b, 1'b0);
        end
        $display("test direct done");
    endtask
    task automatic t_sleep();
        wr(PGC_ADDR_DIRECT, 32'h0000_0000);
        wr(PGC_ADDR_SLEEP, 32'h7FFF_FEFF);
        chk_pwr(32'h7FFF_FEFF, 32'h0000_0000, 1'b0);
        wr(PGC_ADDR_STATE, 32'h0000_0001);
        chk_pwr(32'h7FFF_FEFF, 32'h0000_0000, 1'b1);
        wr(PGC_ADDR_SLEEP, 32'hFFFF_FCFE);
        chk_pwr(32'hFFFF_FCFE, 32'h0000_0000, 1'b1);
        wr(PGC_ADDR_STATE, 32'h0000_0000);
        chk_pwr(32'hFFFF_FCFE, 32'h0000_0000, 1'b0);
        $display("test sleep done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_refuse();
        t_mask();
        t_direct();
        t_sleep();
        finish_test();
    end
endmodule
`default_nettype wire
